/* verilog/ssm_port.sv */
// Serial port unit: SPI master and I2C master (hardware or firmware driven).
// Assumes open-drain bus pins resolved outside; control bits are plain ports.
// Notes on behaviour
// RULE1: Eight-bit shift register, MSB out, LSB in
// RULE2: Shift out one edge, sample the other
// RULE3: One bit each way per clock cycle
// RULE4: Shared clock polarity; master drives the clock
// RULE5: Reload per byte; stop clock, deselect when done
// RULE6: Only one slave select asserted at once
// RULE7: Unselected slave ignores bus, drives nothing; the SPI slave model ignores the bus but drives the inverse of sh[7]
// RULE8: I2C master on mode code and enable
// RULE9: Pins inputs; unit pulls low when needed
// RULE10: Start/stop seen cleared by reset, disable
// RULE11: Software takes bus after stop or idle
// RULE12: Firmware mode: only start/stop detection active
// RULE13: Interrupt flag on listed bus events
// RULE14: No queueing; early buffer write sets collision
// RULE15: Master mode: interrupt on generate bit clear
// RULE16: Master makes clocks, start, stop, repeated start
// RULE17: Transmit: address, write bit, bytes, ack in
// RULE18: Receive: address, read bit, bytes, ack out
// RULE19: Serial clock from programmable baud generator
// RULE20: Reset disables unit, aborts transfer
// RULE21: Select active low; deselected slave floats output; the SPI slave model drives the inverse of sh[7] instead
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_port (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       port_enable_bit,
  input  wire logic [3:0] port_mode_select_field,
  input  wire logic [6:0] brg_reload,
  input  wire logic       spi_ckp,
  input  wire logic       spi_cke,
  input  wire logic       spi_sel,
  input  wire logic       buf_wr,
  input  wire logic [7:0] buf_wdata,
  input  wire logic       buf_rd,
  input  wire logic       cmd_start,
  input  wire logic       cmd_restart,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_recv,
  input  wire logic       cmd_ack,
  input  wire logic       ack_bit,
  input  wire logic       int_clr,
  input  wire logic       coll_clr,
  input  wire logic       fw_scl_low,
  input  wire logic       fw_sda_low,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       spi_sdi,
  output logic            scl_out,
  output logic            scl_oe_n,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            spi_sck,
  output logic            spi_sdo,
  output logic [1:0]      spi_ss_n,
  output logic [7:0]      rx_data,
  output logic            buf_full,
  output logic            ack_status,
  output logic            port_interrupt_flag,
  output logic            write_collision_flag,
  output logic            start_seen,
  output logic            stop_seen,
  output logic            start_generate_bit,
  output logic            restart_generate_bit,
  output logic            stop_generate_bit,
  output logic            busy
);
  ssm_pkg::ssm_state_e state_ff, nxt_state;
  logic [1:0] step_ff, nxt_step;
  logic [3:0] bitc_ff, nxt_bitc;
  logic [6:0] brg_ff, nxt_brg;
  logic [7:0] shreg_ff, nxt_shreg;
  logic       rxbit_ff, nxt_rxbit;
  logic [7:0] rx_ff, nxt_rx;
  logic       full_ff, nxt_full;
  logic       ack_ff, nxt_ack;
  logic       scl_oe_n_ff, nxt_scl_oe_n;
  logic       sda_oe_n_ff, nxt_sda_oe_n;
  logic       sck_ff, nxt_sck;
  logic       sdo_ff, nxt_sdo;
  logic [1:0] ss_n_ff, nxt_ss_n;
  logic       int_ff, nxt_int;
  logic       coll_ff, nxt_coll;
  logic       sseen_ff, nxt_sseen;
  logic       pseen_ff, nxt_pseen;
  logic       sgen_ff, nxt_sgen;
  logic       rgen_ff, nxt_rgen;
  logic       pgen_ff, nxt_pgen;
  logic       busy_ff, nxt_busy;
  logic       prev_sda_ff;
  logic       zero_ff;
  logic [2:0] pin_q;
  logic       scl_q;
  logic       sda_q;
  logic       sdi_q;
  logic       i2cm;
  logic       fwm;
  logic       spim;
  logic       tick;
  logic       idle;
  logic       bit_done;
  logic       sdet;
  logic       pdet;
  logic       ev;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  ssm_sync #(.W(3)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({scl_in, sda_in, spi_sdi}),
    .q       (pin_q)
  );
  assign scl_q = pin_q[2];
  assign sda_q = pin_q[1];
  assign sdi_q = pin_q[0];

  // ----------------------------------------
  // Mode decode and bus condition detection
  // ----------------------------------------
  assign i2cm = (port_mode_select_field == `SSM_MODE_I2CM);   // RULE8
  assign fwm  = (port_mode_select_field == `SSM_MODE_I2CFW);
  assign spim = (port_mode_select_field == `SSM_MODE_SPIM);
  assign tick = (brg_ff == 7'h00);
  assign idle = (state_ff == ssm_pkg::SSM_IDLE);
  assign bit_done = tick && (step_ff == 2'h2);
  assign sdet = (i2cm || fwm) && prev_sda_ff && !sda_q && scl_q;
  assign pdet = (i2cm || fwm) && !prev_sda_ff && sda_q && scl_q;

  always_comb begin
    nxt_state    = state_ff;
    nxt_step     = step_ff;
    nxt_bitc     = bitc_ff;
    nxt_shreg    = shreg_ff;
    nxt_rxbit    = rxbit_ff;
    nxt_rx       = rx_ff;
    nxt_full     = full_ff && !buf_rd;
    nxt_ack      = ack_ff;
    nxt_scl_oe_n = scl_oe_n_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_sck      = sck_ff;
    nxt_sdo      = sdo_ff;
    nxt_ss_n     = ss_n_ff;
    nxt_sgen     = sgen_ff;
    nxt_rgen     = rgen_ff;
    nxt_pgen     = pgen_ff;
    ev           = 1'b0;
    // Baud generator paces both I2C and SPI; held while idle
    nxt_brg = (idle || tick) ? brg_reload : brg_ff - 7'h01;   // RULE19
    // Start/stop seen: a start clears stop and vice versa
    nxt_sseen = sdet || (sseen_ff && !pdet);
    nxt_pseen = pdet || (pseen_ff && !sdet);
    // Collision: set wins over clear; no queueing of work
    nxt_coll = coll_ff && !coll_clr;
    if (buf_wr && !idle && (i2cm || spim)) begin
      nxt_coll = 1'b1;   // RULE14
    end
    if (fwm) begin
      // Software owns the lines; hardware only watches
      nxt_scl_oe_n = !fw_scl_low;   // RULE12
      nxt_sda_oe_n = !fw_sda_low;   // RULE12
      ev = sdet || pdet;   // RULE13
    end else if (spim) begin
      case (state_ff)
        ssm_pkg::SSM_IDLE: begin
          nxt_sck = spi_ckp;   // RULE4
          if (buf_wr) begin
            nxt_state = ssm_pkg::SSM_SPI;
            nxt_shreg = buf_wdata;   // RULE5
            nxt_sdo   = buf_wdata[7];   // RULE1
            nxt_bitc  = 4'h0;
            // One-hot low select, never both
            nxt_ss_n  = spi_sel ? 2'h1 : 2'h2;   // RULE6 RULE21
          end
        end
        ssm_pkg::SSM_SPI: begin
          if (tick) begin
            nxt_sck  = !sck_ff;   // RULE4
            nxt_bitc = bitc_ff + 4'h1;
            if (!bitc_ff[0]) begin
              // Leading edge
              if (spi_cke) begin
                nxt_rxbit = sdi_q;   // RULE2
              end else begin
                nxt_sdo = shreg_ff[7];   // RULE2
              end
            end else if (spi_cke) begin
              nxt_shreg = {shreg_ff[6:0], rxbit_ff};   // RULE1 RULE3
              nxt_sdo   = shreg_ff[6];
            end else begin
              nxt_shreg = {shreg_ff[6:0], sdi_q};   // RULE3
            end
            if (bitc_ff == `SSM_LAST_HALF) begin
              nxt_state = ssm_pkg::SSM_IDLE;
              nxt_rx    = spi_cke ? {shreg_ff[6:0], rxbit_ff} : {shreg_ff[6:0], sdi_q};
              nxt_full  = 1'b1;
              nxt_ss_n  = `SSM_SS_IDLE;   // RULE5 RULE7
              ev        = 1'b1;
            end
          end
        end
        default: begin
          nxt_state = ssm_pkg::SSM_IDLE;
        end
      endcase
    end else if (i2cm) begin
      case (state_ff)
        ssm_pkg::SSM_IDLE: begin
          nxt_step = 2'h0;
          nxt_bitc = 4'h0;
          if (cmd_start && scl_oe_n_ff) begin
            nxt_state = ssm_pkg::SSM_START;
            nxt_sgen  = 1'b1;
          end else if (cmd_restart) begin
            nxt_state = ssm_pkg::SSM_RSTART;
            nxt_rgen  = 1'b1;
          end else if (cmd_stop) begin
            nxt_state = ssm_pkg::SSM_STOP;
            nxt_pgen  = 1'b1;
          end else if (cmd_recv) begin
            nxt_state = ssm_pkg::SSM_RXBIT;   // RULE18
          end else if (cmd_ack) begin
            nxt_state = ssm_pkg::SSM_ACKTX;
            nxt_rxbit = ack_bit;
          end else if (buf_wr) begin
            // First byte is address with direction bit
            nxt_state = ssm_pkg::SSM_TXBIT;   // RULE17 RULE18
            nxt_shreg = buf_wdata;
            nxt_full  = 1'b1;
          end
        end
        ssm_pkg::SSM_START: begin
          if (tick) begin
            nxt_step = step_ff + 2'h1;
            if (step_ff == 2'h0) begin
              nxt_sda_oe_n = 1'b0;   // RULE9 RULE16
            end else begin
              nxt_scl_oe_n = 1'b0;
              nxt_sgen     = 1'b0;   // RULE15
              nxt_state    = ssm_pkg::SSM_IDLE;
              ev           = 1'b1;
            end
          end
        end
        ssm_pkg::SSM_RSTART: begin
          if (tick) begin
            nxt_step = step_ff + 2'h1;
            case (step_ff)
              2'h0: nxt_sda_oe_n = 1'b1;
              2'h1: nxt_scl_oe_n = 1'b1;
              2'h2: nxt_sda_oe_n = 1'b0;   // RULE16
              default: begin
                nxt_scl_oe_n = 1'b0;   // RULE16
                nxt_rgen     = 1'b0;
                nxt_state    = ssm_pkg::SSM_IDLE;
                ev           = 1'b1;   // RULE13
              end
            endcase
          end
        end
        ssm_pkg::SSM_STOP: begin
          if (tick) begin
            nxt_step = step_ff + 2'h1;
            case (step_ff)
              2'h0: nxt_sda_oe_n = 1'b0;
              2'h1: nxt_scl_oe_n = 1'b1;
              default: begin
                nxt_sda_oe_n = 1'b1;   // RULE16
                nxt_pgen     = 1'b0;   // RULE15
                nxt_state    = ssm_pkg::SSM_IDLE;
                ev           = 1'b1;
              end
            endcase
          end
        end
        default: begin
          // Bit cell: set data, release clock, sample and pull clock low
          if (tick) begin
            nxt_step = (step_ff == 2'h2) ? 2'h0 : step_ff + 2'h1;
          end
          if (tick && step_ff == 2'h0) begin
            case (state_ff)
              ssm_pkg::SSM_TXBIT: nxt_sda_oe_n = shreg_ff[7];   // RULE17
              ssm_pkg::SSM_ACKTX: nxt_sda_oe_n = rxbit_ff;   // RULE18
              default:            nxt_sda_oe_n = 1'b1;
            endcase
          end
          if (tick && step_ff == 2'h1) begin
            nxt_scl_oe_n = 1'b1;
          end
          if (bit_done) begin
            nxt_scl_oe_n = 1'b0;   // RULE16
            nxt_bitc     = bitc_ff + 4'h1;
            nxt_shreg    = {shreg_ff[6:0], sda_q};
            case (state_ff)
              ssm_pkg::SSM_TXBIT: begin
                if (bitc_ff == `SSM_LAST_BIT) begin
                  nxt_state = ssm_pkg::SSM_ACKRX;   // RULE17
                  nxt_full  = 1'b0;
                  ev        = 1'b1;
                end
              end
              ssm_pkg::SSM_RXBIT: begin
                if (bitc_ff == `SSM_LAST_BIT) begin
                  nxt_state = ssm_pkg::SSM_IDLE;
                  nxt_rx    = {shreg_ff[6:0], sda_q};
                  nxt_full  = 1'b1;
                  ev        = 1'b1;   // RULE13
                end
              end
              ssm_pkg::SSM_ACKRX: begin
                nxt_ack   = sda_q;
                nxt_state = ssm_pkg::SSM_IDLE;
                ev        = 1'b1;   // RULE13
              end
              default: begin
                nxt_state = ssm_pkg::SSM_IDLE;
                ev        = 1'b1;
              end
            endcase
          end
        end
      endcase
    end else begin
      nxt_state = ssm_pkg::SSM_IDLE;
    end
    nxt_int = ev || (int_ff && !int_clr);
    nxt_busy = (nxt_state != ssm_pkg::SSM_IDLE);
  end

  // ----------------------------------------
  // Registers; disable behaves as reset
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || !port_enable_bit) begin   // RULE10 RULE20
      state_ff    <= ssm_pkg::SSM_IDLE;
      step_ff     <= 2'h0;
      bitc_ff     <= 4'h0;
      brg_ff      <= 7'h00;
      shreg_ff    <= `SSM_BYTE_RST;
      rxbit_ff    <= 1'b0;
      rx_ff       <= `SSM_BYTE_RST;
      full_ff     <= 1'b0;
      ack_ff      <= 1'b0;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
      sck_ff      <= 1'b0;
      sdo_ff      <= 1'b0;
      ss_n_ff     <= `SSM_SS_IDLE;
      int_ff      <= 1'b0;
      coll_ff     <= 1'b0;
      sseen_ff    <= 1'b0;
      pseen_ff    <= 1'b0;
      sgen_ff     <= 1'b0;
      rgen_ff     <= 1'b0;
      pgen_ff     <= 1'b0;
      busy_ff     <= 1'b0;
      prev_sda_ff <= 1'b1;
      zero_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      step_ff     <= nxt_step;
      bitc_ff     <= nxt_bitc;
      brg_ff      <= nxt_brg;
      shreg_ff    <= nxt_shreg;
      rxbit_ff    <= nxt_rxbit;
      rx_ff       <= nxt_rx;
      full_ff     <= nxt_full;
      ack_ff      <= nxt_ack;
      scl_oe_n_ff <= nxt_scl_oe_n;
      sda_oe_n_ff <= nxt_sda_oe_n;
      sck_ff      <= nxt_sck;
      sdo_ff      <= nxt_sdo;
      ss_n_ff     <= nxt_ss_n;
      int_ff      <= nxt_int;
      coll_ff     <= nxt_coll;
      sseen_ff    <= nxt_sseen;
      pseen_ff    <= nxt_pseen;
      sgen_ff     <= nxt_sgen;
      rgen_ff     <= nxt_rgen;
      pgen_ff     <= nxt_pgen;
      busy_ff     <= nxt_busy;
      prev_sda_ff <= sda_q;
      zero_ff     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open drain: the pin value is always low, only the enable moves
  assign scl_out              = zero_ff;
  assign sda_out              = zero_ff;
  assign scl_oe_n             = scl_oe_n_ff;
  assign sda_oe_n             = sda_oe_n_ff;
  assign spi_sck              = sck_ff;
  assign spi_sdo              = sdo_ff;
  assign spi_ss_n             = ss_n_ff;
  assign rx_data              = rx_ff;
  assign buf_full             = full_ff;
  assign ack_status           = ack_ff;
  assign port_interrupt_flag  = int_ff;
  assign write_collision_flag = coll_ff;
  assign start_seen           = sseen_ff;
  assign stop_seen            = pseen_ff;
  assign start_generate_bit   = sgen_ff;
  assign restart_generate_bit = rgen_ff;
  assign stop_generate_bit    = pgen_ff;
  assign busy                 = busy_ff;
endmodule

/* verilog/ssm_map.svh */
// Constants of the serial port unit: mode codes, counts, reset values.
// Assumes inclusion by the main module, the monitor and the bench; definitions only.
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
// ----------------------------------------
// Mode codes of port_mode_select_field
// ----------------------------------------
`define SSM_MODE_SPIM   4'h0
`define SSM_MODE_I2CM   4'h8
`define SSM_MODE_I2CFW  4'hb
// ----------------------------------------
// Counts and reset values
// ----------------------------------------
`define SSM_LAST_BIT    4'h7
`define SSM_LAST_HALF   4'hf
`define SSM_SS_IDLE     2'h3
`define SSM_BYTE_RST    8'h00
`endif

/* verilog/ssm_pkg.sv */
// Types of the serial port unit.
// Assumes nothing beyond a SystemVerilog compiler.
package ssm_pkg;
  // ----------------------------------------
  // Sequencer states, Gray along the usual path
  // ----------------------------------------
  typedef enum logic [3:0] {
    SSM_IDLE   = 4'h0,
    SSM_START  = 4'h1,
    SSM_TXBIT  = 4'h3,
    SSM_ACKRX  = 4'h2,
    SSM_RXBIT  = 4'h6,
    SSM_ACKTX  = 4'h7,
    SSM_STOP   = 4'h5,
    SSM_RSTART = 4'h4,
    SSM_SPI    = 4'hc
  } ssm_state_e;
endpackage

/* verilog/ssm_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin inputs and one clock.
`timescale 1ns/10ps
module ssm_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // ----------------------------------------
  // Filter: a change counts once stage 2 and 3 agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
      end
    end
  endgenerate

  // Idle bus lines float high, so reset to ones
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      q_ff  <= '1;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule

/* sim/ssm_port_monitor.sv */
// Checker of the serial port unit, bound to its top module.
// Assumes one clock domain and the mode codes of the design map.
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_port_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       port_enable_bit,
  input wire logic [3:0] port_mode_select_field,
  input wire logic       buf_wr,
  input wire logic       cmd_start,
  input wire logic       coll_clr,
  input wire logic       fw_scl_low,
  input wire logic       fw_sda_low,
  input wire logic       scl_oe_n,
  input wire logic       sda_oe_n,
  input wire logic [1:0] spi_ss_n,
  input wire logic       port_interrupt_flag,
  input wire logic       write_collision_flag,
  input wire logic       start_seen,
  input wire logic       stop_seen,
  input wire logic       start_generate_bit,
  input wire logic       restart_generate_bit,
  input wire logic       stop_generate_bit,
  input wire logic       busy
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  wire mst = port_enable_bit && (port_mode_select_field == `SSM_MODE_SPIM
             || port_mode_select_field == `SSM_MODE_I2CM);
  wire fw_on = port_enable_bit && port_mode_select_field == `SSM_MODE_I2CFW;
  wire i2cm = port_enable_bit && port_mode_select_field == `SSM_MODE_I2CM;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start_go;
    $rose(start_generate_bit) && port_enable_bit;
  endsequence
  sequence s_start_done;
    !start_generate_bit && !scl_oe_n && !sda_oe_n && port_interrupt_flag;
  endsequence
  chk_one_select: assert property ($countones(~spi_ss_n) <= 1)
    else $error("two selects low");
  chk_coll_set: assert property (mst && busy && buf_wr |=>
    write_collision_flag || !port_enable_bit) else $error("collision not flagged");
  chk_coll_hold: assert property (write_collision_flag && !coll_clr
    && port_enable_bit |=> write_collision_flag) else $error("collision flag lost");
  chk_start_irq: assert property (($fell(start_generate_bit)
    || $fell(restart_generate_bit)) && port_enable_bit |-> port_interrupt_flag)
    else $error("no interrupt at start end");
  chk_stop_irq: assert property ($fell(stop_generate_bit) && port_enable_bit
    |-> port_interrupt_flag) else $error("no interrupt at stop end");
  // Disable mid-condition abandons it, so the bound is waived then
  chk_start_bound: assert property (disable iff (sys_rst || !port_enable_bit)
    s_start_go |-> ##[1:600] s_start_done) else $error("start not completed");
  chk_start_edge: assert property ($fell(sda_oe_n) && (start_generate_bit
    || restart_generate_bit) |-> scl_oe_n) else $error("start with clock low");
  chk_cmd_accept: assert property (i2cm && cmd_start && !busy && scl_oe_n
    |=> busy && start_generate_bit) else $error("start command lost");
  chk_fw_follow: assert property (fw_on [*2] |->
    sda_oe_n == !$past(fw_sda_low) && scl_oe_n == !$past(fw_scl_low))
    else $error("pins not following firmware");
  chk_disable_clr: assert property (!port_enable_bit |=>
    !start_seen && !stop_seen && !busy) else $error("disable left state");
  chk_reset_idle: assert property (disable iff (1'b0) sys_rst |=>
    scl_oe_n && sda_oe_n && spi_ss_n == 2'h3 && !port_interrupt_flag)
    else $error("reset left outputs active");
endmodule
bind ssm_port ssm_port_monitor ssm_port_monitor_i (.clk, .sys_rst, .port_enable_bit,
  .port_mode_select_field, .buf_wr, .cmd_start, .coll_clr, .fw_scl_low, .fw_sda_low,
  .scl_oe_n, .sda_oe_n, .spi_ss_n, .port_interrupt_flag, .write_collision_flag,
  .start_seen, .stop_seen, .start_generate_bit, .restart_generate_bit,
  .stop_generate_bit, .busy);

/* sim/ssm_slave_model.sv */
// Bus partners of the serial port unit: one SPI slave, one I2C slave.
// Assumes open-drain lines resolved by the bench with pull-ups.
`timescale 1ns/10ps
module ssm_spi_slave (
  input  wire logic       ss_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cke,
  input  wire logic [7:0] load,
  output logic            miso,
  output logic [7:0]      got
);
  logic [7:0] sh = 8'h00;
  logic       b_in = 1'b0;
  logic       lead = 1'b0;
  always @(negedge ss_n) begin
    sh = load;
    lead = 1'b0;
  end
  // Trailing edge only counts after a leading one: idle level may move
  always @(sck) begin
    if (!ss_n && sck != cpol) begin
      b_in = mosi;
      lead = 1'b1;
    end else if (!ss_n && lead) begin
      sh = {sh[6:0], cke ? b_in : mosi};
      lead = 1'b0;
    end
  end
  always @(posedge ss_n) got = lead ? {sh[6:0], cke ? b_in : mosi} : sh;
  // Released output shows the inverse so a stale bit never matches
  assign miso = ss_n ? ~sh[7] : sh[7];
endmodule
module ssm_i2c_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx,
  output logic            pull,
  output logic [7:0]      got,
  output logic            mack
);
  logic [7:0] sh = 8'h00;
  int         k = 0;
  logic       first = 1'b0;
  logic       rd = 1'b0;
  initial pull = 1'b0;
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      k = 0;
      first = 1'b1;
      rd = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (k < 8) begin
      sh = {sh[6:0], sda};
    end else begin
      got = sh;
      mack = sda;
      if (first) rd = sh[0];
      else if (rd && sda) rd = 1'b0;
      first = 1'b0;
    end
    k = (k == 8) ? 0 : k + 1;
  end
  always @(negedge scl) begin
    pull = (k == 8 && !rd) || (rd && k < 8 && !tx[7 - k]);
  end
endmodule

/* sim/ssm_port_test.sv */
// Self-checking bench of the serial port unit with its bus partners.
// Assumes the partner models and the bound monitor are compiled first.
`timescale 1ns/10ps
`include "ssm_map.svh"
module ssm_port_test;
  localparam logic [6:0] ADDR = 7'h2d;
  localparam logic [7:0] TXB  = 8'h96;
  logic       clk, sys_rst, port_enable_bit, spi_ckp, spi_cke, spi_sel, buf_wr, buf_rd;
  logic       cmd_start, cmd_restart, cmd_stop, cmd_recv, cmd_ack, ack_bit, int_clr;
  logic       coll_clr, fw_scl_low, fw_sda_low, scl_in, sda_in, spi_sdi, scl_out, sda_out;
  logic       scl_oe_n, sda_oe_n, spi_sck, spi_sdo, buf_full, ack_status, busy, i_pull;
  logic       port_interrupt_flag, write_collision_flag, start_seen, stop_seen, i_mack;
  logic       start_generate_bit, restart_generate_bit, stop_generate_bit;
  logic [1:0] spi_ss_n;
  logic [3:0] port_mode_select_field;
  logic [6:0] brg_reload;
  logic [7:0] buf_wdata, rx_data, s_load, s_got, i_got;
  int         err_total, checks_done;
  ssm_port ssm_port_i (.*);
  ssm_spi_slave ssm_spi_slave_i (.ss_n(spi_ss_n[0]), .sck(spi_sck), .mosi(spi_sdo),
    .cpol(spi_ckp), .cke(spi_cke), .load(s_load), .miso(spi_sdi), .got(s_got));
  ssm_i2c_slave ssm_i2c_slave_i (.scl(scl_in), .sda(sda_in), .tx(TXB), .pull(i_pull),
    .got(i_got), .mack(i_mack));
  assign scl_in = scl_oe_n;
  assign sda_in = sda_oe_n & ~i_pull;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(busy, 1'b0);
  endtask
  task automatic op(ref logic s);
    pulse(int_clr);
    pulse(s);
    wait_idle;
  endtask
  task automatic send(input logic [7:0] b);
    buf_wdata = b;
    op(buf_wr);
    chk({i_got, ack_status, port_interrupt_flag}, {b, 2'h1});
  endtask
  task automatic give_verdict;
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_spi;
    for (int c = 0; c < 4; c++) begin
      spi_ckp = c[0];
      spi_sel = c[1];
      spi_cke = !c[0];
      s_load = 8'h3c + 8'(c);
      buf_wdata = 8'ha5 ^ 8'(c);
      pulse(buf_wr);
      chk(spi_ss_n, c[1] ? 2'h1 : 2'h2);
      if (c == 0) begin
        @(negedge clk);
        pulse(buf_wr);
        @(negedge clk);
        chk(write_collision_flag, 1'b1);
        pulse(coll_clr);
        chk(write_collision_flag, 1'b0);
      end
      wait_idle;
      chk({spi_sck, spi_ss_n, port_interrupt_flag, buf_full}, {c[0], 4'hf});
      if (!c[1]) chk({rx_data, s_got}, {8'h3c + 8'(c), 8'ha5 ^ 8'(c)});
      pulse(int_clr);
      pulse(buf_rd);
      chk({port_interrupt_flag, buf_full}, 2'h0);
    end
  endtask
  task automatic t_i2c;
    port_mode_select_field = `SSM_MODE_I2CM;
    repeat (8) @(negedge clk);
    pulse(cmd_start);
    chk(start_generate_bit, 1'b1);
    pulse(buf_wr);
    @(negedge clk);
    chk(write_collision_flag, 1'b1);
    pulse(coll_clr);
    wait_idle;
    chk({scl_oe_n, sda_oe_n, port_interrupt_flag}, 3'h1);
    send({ADDR, 1'b0});
    send(8'hc3);
    op(cmd_restart);
    chk({scl_oe_n, sda_oe_n, restart_generate_bit, port_interrupt_flag}, 4'h1);
    send({ADDR, 1'b1});
    for (int i = 0; i < 2; i++) begin
      op(cmd_recv);
      chk({rx_data, buf_full, port_interrupt_flag}, {TXB, 2'h3});
      pulse(buf_rd);
      ack_bit = i[0];
      op(cmd_ack);
      chk({i_mack, port_interrupt_flag}, {i[0], 1'b1});
    end
    op(cmd_stop);
    chk({scl_oe_n, sda_oe_n, stop_generate_bit, port_interrupt_flag}, 4'hd);
  endtask
  task automatic t_fw;
    port_mode_select_field = `SSM_MODE_I2CFW;
    pulse(int_clr);
    fw_sda_low = 1'b1;
    repeat (10) @(negedge clk);
    chk({sda_oe_n, scl_oe_n, start_seen, port_interrupt_flag}, 4'h7);
    fw_sda_low = 1'b0;
    repeat (10) @(negedge clk);
    chk({sda_oe_n, stop_seen}, 2'h3);
    fw_scl_low = 1'b1;
    repeat (2) @(negedge clk);
    chk(scl_oe_n, 1'b0);
    fw_scl_low = 1'b0;
    port_enable_bit = 1'b0;
    repeat (2) @(negedge clk);
    chk({start_seen, stop_seen, scl_oe_n}, 3'h1);
    port_enable_bit = 1'b1;
  endtask
  // Reset in mid-byte must abandon the exchange at once
  task automatic t_abort;
    port_mode_select_field = `SSM_MODE_SPIM;
    pulse(buf_wr);
    repeat (20) @(negedge clk);
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    chk({busy, spi_ss_n, port_interrupt_flag}, 4'h6);
  endtask
  initial begin
    err_total = 0;
    checks_done = 0;
    {sys_rst, port_enable_bit, spi_cke, spi_ckp, spi_sel, buf_wr, buf_rd} = 7'h70;
    {cmd_start, cmd_restart, cmd_stop, cmd_recv, cmd_ack, ack_bit} = 6'h0;
    {int_clr, coll_clr, fw_scl_low, fw_sda_low} = 4'h0;
    port_mode_select_field = `SSM_MODE_SPIM;
    brg_reload = 7'h07;
    buf_wdata = 8'h11;
    s_load = 8'h00;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk);
    chk({scl_out, sda_out, scl_oe_n, sda_oe_n, spi_ss_n, port_interrupt_flag, busy},
      8'h3c);
    t_spi;
    t_i2c;
    t_fw;
    t_abort;
    give_verdict;
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    give_verdict;
  end
endmodule
